// ---- design/alfo_defines.vh ----
// Constants for the add and literal/file execution datapath.
// Assumes a 14-bit instruction word and an 8-bit working register.
// Overview of operation
// - Literal add: W plus literal into W, flags.
// - Literal AND: W and literal, only zero updated.
// - Literal results go to W, never file.
// - File add: W plus addressed file, flags.
// - Destination clear: sum to W, file untouched.
// - Destination set: sum to file, W untouched.
`ifndef ALFO_DEFINES_VH
`define ALFO_DEFINES_VH

// Instruction word width and fields
`define ALFO_IW           14
`define ALFO_LIT_MSB      7
`define ALFO_ADDR_MSB     6
`define ALFO_DEST_BIT     7
// Opcode matches on instruction bits 13:8 (literal add ignores bit 8)
`define ALFO_OP_ADDLIT    5'h1f
`define ALFO_OP_ANDLIT    6'h39
`define ALFO_OP_ADDFILE   6'h07
// Reset values
`define ALFO_WORK_RST     8'h00
`define ALFO_FLAG_RST     1'b0
// Operation select codes for the arithmetic unit
`define ALFO_OPSEL_ADD    1'b0
`define ALFO_OPSEL_AND    1'b1

`endif

// ---- design/alfo_alu.v ----
// Combinational 8-bit add/AND unit with carry, digit carry and zero.
// Assumes the caller registers the results and picks which flags apply.
`timescale 1ns/10ps
`include "alfo_defines.vh"

module alfo_alu #(
  parameter W = 8
) (
  input  wire [W-1:0] op_a,
  input  wire [W-1:0] op_b,
  input  wire         opsel,
  output reg  [W-1:0] result,
  output reg          carry,
  output reg          digit_carry,
  output reg          zero
);

  reg [W:0] sum;   // Full sum with carry out
  reg [4:0] low;   // Low nibble sum with carry out

  // Compute result and flags
  always @* begin
    sum = {1'b0, op_a} + {1'b0, op_b};
    low = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
    if (opsel == `ALFO_OPSEL_AND) begin
      result = op_a & op_b;
    end else begin
      result = sum[W-1:0];
    end
    carry       = sum[W];
    digit_carry = low[4];
    zero        = (result == {W{1'b0}});
  end

endmodule

// ---- design/alfo_core.v ----
// Execution stage for literal add, literal AND and add work to file.
// Assumes instr_valid marks one instruction per cycle and that file_rdata
// already holds the register addressed by the instruction this cycle.
// Results, flags and the write port all appear one clock after the word;
// the register file itself lives outside and takes the write port.
`timescale 1ns/10ps
`include "alfo_defines.vh"

module alfo_core #(
  parameter W = 8
) (
  input  wire           clk,
  input  wire           rst_b,
  input  wire           instr_valid,
  input  wire [13:0]    instr,
  input  wire [W-1:0]   file_rdata,
  output reg  [W-1:0]   work,
  output reg            carry_flag,
  output reg            digit_carry_flag,
  output reg            zero_flag,
  output reg            file_we,
  output reg  [6:0]     file_waddr,
  output reg  [W-1:0]   file_wdata,
  output reg            instr_done
);

  // Instruction class codes, one bit per kind of word
  localparam [3:0] CLS_NONE     = 4'h1;  // Nothing recognised this cycle
  localparam [3:0] CLS_ADD_LIT  = 4'h2;  // Literal add
  localparam [3:0] CLS_AND_LIT  = 4'h4;  // Literal AND
  localparam [3:0] CLS_ADD_FILE = 4'h8;  // Add work to file

  wire         add_literal_to_work;    // Literal add decoded
  wire         and_literal_with_work;  // Literal AND decoded
  wire         add_work_to_file;       // File add decoded
  wire         dest_file;              // Destination bit of file add
  reg  [3:0]   instr_class;            // One-hot class of this word
  reg  [W-1:0] op_b;                   // Second operand
  wire         alu_opsel;              // Add or AND select
  wire [W-1:0] alu_result;             // Unit result
  wire         alu_c;                  // Carry out of bit 7
  wire         alu_digit;              // Carry out of bit 3
  wire         alu_z;                  // Result is zero

  // Next values of every output register
  reg  [W-1:0] next_work;              // Working register
  reg          next_carry_flag;        // Carry flag
  reg          next_digit_carry_flag;  // Digit carry flag
  reg          next_zero_flag;         // Zero flag
  reg          next_file_we;           // File write strobe
  reg  [6:0]   next_file_waddr;        // File write address
  reg  [W-1:0] next_file_wdata;        // File write data
  reg          next_instr_done;        // Completion pulse

  // Opcode decode. The literal add ignores bit 8 of the word, so both
  // of its encodings are taken; every other word is left alone.
  // literal add opcode
  assign add_literal_to_work   = instr_valid && (instr[13:9] == `ALFO_OP_ADDLIT);
  assign and_literal_with_work = instr_valid && (instr[13:8] == `ALFO_OP_ANDLIT);
  assign add_work_to_file      = instr_valid && (instr[13:8] == `ALFO_OP_ADDFILE);
  assign dest_file             = instr[`ALFO_DEST_BIT];

  // Pick literal or file register as second operand
  always @* begin
    if (add_work_to_file) begin
      op_b = file_rdata;
    end else begin
      op_b = instr[`ALFO_LIT_MSB:0];
    end
  end

  // AND only for the literal AND; every other word adds
  assign alu_opsel = and_literal_with_work ? `ALFO_OPSEL_AND : `ALFO_OPSEL_ADD;

  // Shared arithmetic unit
  alfo_alu #(
    .W (W)
  ) u_alu (
    .op_a        (work),
    .op_b        (op_b),
    .opsel       (alu_opsel),
    .result      (alu_result),
    .carry       (alu_c),
    .digit_carry (alu_digit),
    .zero        (alu_z)
  );

  // Word classification. The three opcodes differ in bits 13:8, so at
  // most one decode is true; the priority below only keeps the class
  // strictly one-hot for the case statement that follows.
  always @* begin
    if (add_literal_to_work) begin
      // Literal add, either encoding of bit 8
      instr_class = CLS_ADD_LIT;
    end else if (and_literal_with_work) begin
      // Literal AND
      instr_class = CLS_AND_LIT;
    end else if (add_work_to_file) begin
      // Add work to the addressed file register
      instr_class = CLS_ADD_FILE;
    end else begin
      // Unrecognised word or no valid word
      instr_class = CLS_NONE;
    end
  end

  // Next state of the working register, the flags and the write port.
  // Work, flags, address and data first hold and the strobes drop; only a
  // recognised word moves them, so a refused word leaves work, flags, address and data as they were.
  always @* begin
    // Hold by default
    next_work             = work;
    next_carry_flag       = carry_flag;
    next_digit_carry_flag = digit_carry_flag;
    next_zero_flag        = zero_flag;
    // Address and data keep the last write so a slow reader still sees it
    next_file_waddr       = file_waddr;
    next_file_wdata       = file_wdata;
    // Strobes are single-cycle pulses
    next_file_we          = 1'b0;
    next_instr_done       = 1'b0;
    case (instr_class)
      CLS_ADD_LIT: begin
        next_work             = alu_result;
        next_carry_flag       = alu_c;
        next_digit_carry_flag = alu_digit;
        next_zero_flag        = alu_z;
        next_file_we          = 1'b0;
        next_instr_done       = 1'b1;
      end
      CLS_AND_LIT: begin
        next_zero_flag        = alu_z;
        next_work             = alu_result;
        next_file_we          = 1'b0;
        next_instr_done       = 1'b1;
      end
      CLS_ADD_FILE: begin
        next_carry_flag       = alu_c;
        next_digit_carry_flag = alu_digit;
        next_zero_flag        = alu_z;
        next_instr_done       = 1'b1;
        if (dest_file) begin
          next_file_we        = 1'b1;
          next_file_waddr     = instr[`ALFO_ADDR_MSB:0];
          next_file_wdata     = alu_result;
        end else begin
          next_work           = alu_result;
        end
      end
      CLS_NONE: begin
        // Refused word: everything holds, no pulse
        next_instr_done       = 1'b0;
      end
      default: begin
        // Class never leaves the one-hot set; hold as above
        next_instr_done       = 1'b0;
      end
    endcase
  end

  // Working register; cleared by the synchronous reset
  always @(posedge clk) begin
    if (!rst_b) begin
      // Known operand for the first word after reset
      work <= `ALFO_WORK_RST;
    end else begin
      // Operand of the next word is the value left by this one
      work <= next_work;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      // All flags start clear
      carry_flag       <= `ALFO_FLAG_RST;
      digit_carry_flag <= `ALFO_FLAG_RST;
      zero_flag        <= `ALFO_FLAG_RST;
    end else begin
      // Each flag only moves when its word updates it
      carry_flag       <= next_carry_flag;
      digit_carry_flag <= next_digit_carry_flag;
      zero_flag        <= next_zero_flag;
    end
  end

  // File write port: strobe, address and data leave from flip-flops, so
  // the register file sees no combinational path from the decode
  always @(posedge clk) begin
    if (!rst_b) begin
      // No write pending, address and data parked at zero
      file_we    <= 1'b0;
      file_waddr <= 7'h00;
      file_wdata <= {W{1'b0}};
    end else begin
      // Strobe for one cycle, address and data until the next write
      file_we    <= next_file_we;
      file_waddr <= next_file_waddr;
      file_wdata <= next_file_wdata;
    end
  end

  // Completion pulse, one cycle per recognised word
  always @(posedge clk) begin
    if (!rst_b) begin
      // Nothing completes during reset
      instr_done <= 1'b0;
    end else begin
      // Back-to-back words give back-to-back pulses
      instr_done <= next_instr_done;
    end
  end

endmodule

// ---- verification/alfo_core_props.sv ----
// Checker for the add and literal/file stage.
// Sees only the stage's ports; bound below.
`timescale 1ns/10ps
module alfo_core_props #(
  parameter W = 8
) (
  input logic         clk,
  input logic         rst_b,
  input logic         instr_valid,
  input logic [13:0]  instr,
  input logic [W-1:0] file_rdata,
  input logic [W-1:0] work,
  input logic [W-1:0] file_wdata,
  input logic [6:0]   file_waddr,
  input logic         carry_flag,
  input logic         digit_carry_flag,
  input logic         zero_flag,
  input logic         file_we,
  input logic         instr_done
);
  // Decode and expected sums
  wire al = instr_valid && instr[13:9] == 5'h1f;
  wire nl = instr_valid && instr[13:8] == 6'h39;
  wire af = instr_valid && instr[13:8] == 6'h07;
  wire [W-1:0] b = af ? file_rdata : instr[7:0];
  wire [W:0] s = work + b;
  wire [4:0] d = work[3:0] + b[3:0];
  wire [W-1:0] a = work & instr[7:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_addlit_sum: assert property (al |=> work == $past(s[W-1:0]))
    else $error("literal add result wrong");
  chk_and_flags: assert property (nl |=> work == $past(a) && $stable(carry_flag)
    && $stable(digit_carry_flag) && zero_flag == ($past(a) == 0)) else $error("and wrong");
  chk_lit_nofile: assert property (al || nl |=> !file_we && instr_done)
    else $error("literal wrote a file");
  chk_file_work: assert property (af && !instr[7] |=> work == $past(s[W-1:0]))
    else $error("file add to work wrong");
  chk_work_dest: assert property (af && !instr[7] |=> !file_we)
    else $error("file written for work dest");
  chk_file_dest: assert property (af && instr[7] |=> file_we && $stable(work)
    && file_wdata == $past(s[W-1:0]) && file_waddr == $past(instr[6:0])) else $error("dest");
  chk_flag_bits: assert property (al || af |=> carry_flag == $past(s[W])
    && digit_carry_flag == $past(d[4]) && zero_flag == ($past(s[W-1:0]) == 0))
    else $error("add flags wrong");
endmodule
bind alfo_core alfo_core_props #(.W(W)) alfo_core_props_i (.clk(clk), .rst_b(rst_b),
  .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata), .work(work),
  .file_wdata(file_wdata), .file_waddr(file_waddr), .carry_flag(carry_flag),
  .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag), .file_we(file_we),
  .instr_done(instr_done));

// ---- verification/testbench.sv ----
// Self-checking bench for the add and literal/file stage.
// Drives inputs on the falling edge; a bench model predicts results.
`timescale 1ns/10ps
module testbench;
  logic clk = 0, rst_b = 0, instr_valid = 0, c = 0, dcf = 0, z = 0, fe = 0, dn = 0;
  logic [13:0] instr = 0;
  logic [7:0] file_rdata = 0, w = 0, fd = 0;
  logic [6:0] fa = 0;
  logic [9:0] s;
  logic [31:0] r;
  wire [7:0] work, file_wdata;
  wire [6:0] file_waddr;
  wire carry_flag, digit_carry_flag, zero_flag, file_we, instr_done;
  wire [4:0] flg = {carry_flag, digit_carry_flag, zero_flag, file_we, instr_done};
  integer seed = 23, fails = 0, tests_run = 0, i;
  alfo_core alfo_core_i (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr(instr), .file_rdata(file_rdata), .work(work), .carry_flag(carry_flag),
    .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .instr_done(instr_done));
  initial forever #5 clk = ~clk;
  // Sum with digit carry on top
  function [9:0] add(input [7:0] x, y);
    add = {({1'b0, x[3:0]} + y[3:0]) > 5'h0f, {1'b0, x} + y};
  endfunction
  // Hand-written words: the worked examples, a carry out and a zero sum
  function [13:0] corner(input integer k);
    case (k)
      0: corner = 14'h3e10;
      1: corner = 14'h3e15;
      2: corner = 14'h3e7e;
      3: corner = 14'h395f;
      4: corner = 14'h3e14;
      5: corner = 14'h0782;
      6: corner = 14'h0702;
      7: corner = 14'h3fff;
      default: corner = 14'h3e28;
    endcase
  endfunction
  task chk(input string n, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task wrap_up;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well past the run length
  initial begin
    #20000;
    fails++;
    wrap_up;
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1;
    for (i = 0; i < 500; i++) begin
      r = $random(seed);
      // Corner words first, then random kinds
      instr = i < 9 ? corner(i) : {r[9:8] == 0 ?
        {5'h1f, r[10]} : r[9:8] == 1 ? 6'h39 : r[9:8] == 2 ? 6'h07 : r[15:10], r[7:0]};
      instr_valid = i < 9 || r[16];
      file_rdata = i < 9 ? 8'hc2 : r[31:24];
      dn = instr_valid && (instr[13:9] == 5'h1f || instr[13:8] == 6'h39 || instr[13:8] == 6'h07);
      fe = dn && instr[13:8] == 6'h07 && instr[7];
      if (dn && instr[13:8] == 6'h39) begin
        w = w & instr[7:0];
        z = w == 0;
      end else if (dn) begin
        s = add(w, instr[13] ? instr[7:0] : file_rdata);
        {dcf, c, z} = {s[9:8], s[7:0] == 0};
        if (fe) {fa, fd} = {instr[6:0], s[7:0]};
        else w = s[7:0];
      end
      @(negedge clk);
      chk("work", w, work);
      chk("flags", {c, dcf, z, fe, dn}, flg);
      chk("waddr", fa, file_waddr);
      chk("wdata", fd, file_wdata);
      if (i == 1) chk("lit add example", 8'h25, work);
      if (i == 3) chk("lit and example", 8'h03, work);
      if (i == 5) chk("file dest example", 8'hd9, file_wdata);
      if (i == 6) chk("work dest example", 8'hd9, work);
    end
    $display("random instruction run done");
    wrap_up;
  end
endmodule
